// ---- sim/diff_transient_restraint_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module diff_transient_restraint_tb_top
	import dtr_pkg::*;
;
	// ********************
	// Stimulus and wiring
	// ********************
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] gap = 8'h09;
	logic [2:0][15:0] amp = '0;
	logic swing = 1'b0;
	logic through = 1'b0;
	logic sample_valid;
	logic [2:0][15:0] w1_sample;
	logic [2:0][15:0] w2_sample;
	logic [2:0][7:0] h2_pct = '0;
	logic [2:0][7:0] h4_pct = '0;
	logic [2:0][7:0] h5_pct = '0;
	logic [2:0][15:0] static_level = {3{16'h7FFF}};
	logic energize_pin = 1'b0;
	logic [2:0] trip;
	logic [2:0] restraint_active;
	logic irq;
	int error_cnt = 0;
	int compares = 0;
	logic [31:0] rv;
	logic [7:0] ra [13] = '{ADDR_CTRL, ADDR_HARM_TRA, ADDR_HARM_STA, ADDR_OFFSET_MULT,
		ADDR_T_TRANS, ADDR_MAX_STAB, ADDR_SAT_LEVEL, ADDR_POWER, ADDR_VOLT_W1,
		ADDR_VOLT_W2, ADDR_MATCH, 8'h3C, 8'h02};
	logic [31:0] rd_exp [13] = '{32'(CTRL_RST), 32'({FIFTH_HARM_TRANSIENT_LEVEL_RST, SECOND_HARM_TRANSIENT_LEVEL_RST}),
		32'({FIFTH_HARM_STEADY_LEVEL_RST, FOURTH_HARM_STEADY_LEVEL_RST, SECOND_HARM_STEADY_LEVEL_RST}), 32'(OFFSET_MULT_RST), 32'(T_TRANS_RST),
		32'(MAX_STAB_RST), 32'(SAT_LEVEL_RST), 32'(POWER_RST), 32'(VOLT_RST), 32'(VOLT_RST),
		32'(MATCH_RST), 32'h0000_0000, 32'h0000_0000};

	always #50 core_clk = ~core_clk;

	// Short ms tick keeps the window and lockout times simulable
	dtr_core #(.TICK_CYCLES(4)) dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.sample_valid(sample_valid),
		.w1_sample(w1_sample),
		.w2_sample(w2_sample),
		.h2_pct(h2_pct),
		.h4_pct(h4_pct),
		.h5_pct(h5_pct),
		.static_level(static_level),
		.energize_pin(energize_pin),
		.trip(trip),
		.restraint_active(restraint_active),
		.irq(irq)
	);

	dtr_ct_model u_ct (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.gap(gap),
		.amp(amp),
		.swing(swing),
		.through(through),
		.sample_valid(sample_valid),
		.w1_sample(w1_sample),
		.w2_sample(w2_sample)
	);

	// ********************
	// Tasks
	// ********************
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
		chk(what, rv, exp);
	endtask

	// Long enough for several samples at the slow pace
	task automatic rs(input logic [2:0] exp);
		wait_cyc(40);
		chk("restraint", 32'(restraint_active), 32'(exp));
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ********************
	// Scenarios
	// ********************
	initial
	begin
		wait_cyc(2);
		rst_n <= 1'b1;
		for (int i = 0; i < 13; i++)
			rchk("register", ra[i], rd_exp[i]);
		wait_cyc(150);
		rchk("base", ADDR_BASE, 32'h0241_0241);
		wr(ADDR_VOLT_W2, 32'h0000_1388);
		wait_cyc(150);
		rchk("base", ADDR_BASE, 32'h0482_0241);
		@(posedge core_clk);
		h2_pct[0] <= 8'h15;
		h4_pct[1] <= 8'h15;
		h5_pct[2] <= 8'h1F;
		rs(3'h7);
		for (int k = 0; k < 3; k++)
		begin
			wr(ADDR_CTRL, 32'h0000_000F ^ (32'h0000_0001 << k));
			rs(3'h7 ^ (3'h1 << k));
		end
		wr(ADDR_CTRL, 32'h0000_0010);
		rs(3'h0);
		h2_pct[0] <= 8'h14;
		h5_pct[2] <= 8'h1E;
		wr(ADDR_CTRL, 32'h0000_001F);
		rs(3'h7);
		h4_pct[1] <= 8'h14;
		rs(3'h0);
		wr(ADDR_CTRL, 32'h0000_000F);
		wr(ADDR_T_TRANS, 32'h0000_0014);
		h2_pct[0] <= 8'h10;
		energize_pin <= 1'b1;
		rs(3'h1);
		wait_cyc(100);
		rs(3'h0);
		h2_pct[0] <= 8'h00;
		gap <= 8'h02;
		rchk("status", ADDR_STATUS, 32'h0000_0001 << ST_TRANS_END_BIT);
		wr(ADDR_MASK, 32'h0000_0001);
		static_level[0] <= 16'h0258;
		amp[0] <= 16'h0258;
		wait_cyc(40);
		chk("trip", 32'(trip), 32'h0000_0001);
		chk("irq", 32'(irq), 32'h0000_0001);
		rchk("status", ADDR_STATUS, 32'h0000_0001);
		chk("irq", 32'(irq), 32'h0000_0000);
		h4_pct[0] <= 8'h15;
		rs(3'h1);
		chk("trip", 32'(trip), 32'h0000_0000);
		amp[0] <= 16'h03E8;
		wait_cyc(40);
		chk("trip", 32'(trip), 32'h0000_0000);
		wr(ADDR_OFFSET_MULT, 32'h0000_0008);
		wait_cyc(40);
		chk("trip", 32'(trip), 32'h0000_0001);
		h4_pct[0] <= 8'h00;
		swing <= 1'b1;
		rs(3'h0);
		through <= 1'b1;
		wait_cyc(20);
		rs(3'h1);
		through <= 1'b0;
		wait_cyc(30);
		rs(3'h0);
		through <= 1'b1;
		wait_cyc(60);
		rs(3'h0);
		through <= 1'b0;
		wr(ADDR_MAX_STAB, 32'h0000_0032);
		wait_cyc(4000);
		through <= 1'b1;
		wait_cyc(20);
		rs(3'h1);
		wait_cyc(220);
		rs(3'h0);
		rchk("status", ADDR_STATUS, 32'h0000_0001 | (32'h0000_0001 << ST_SAT_START_BIT)
			| (32'h0000_0001 << ST_SAT_END_BIT));
		rst_n <= 1'b0;
		wait_cyc(2);
		rst_n <= 1'b1;
		rchk("register", ADDR_CTRL, 32'(CTRL_RST));
		complete_run();
	end

	// Hang guard, about twice the expected run
	initial
	begin
		#1200000;
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire

// ---- sim/dtr_core_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module dtr_core_assertions
	import dtr_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Measurement and results
	input wire logic [2:0][7:0] h4_pct,
	input wire logic [2:0] trip,
	input wire logic [2:0] restraint_active,
	input wire logic irq
);
	// ********************
	// Shadows of settings
	// ********************
	logic [4:0] ctrl_sh;
	logic [7:0] h4_sh;
	logic [31:0] mask_sh;
	logic [5:0] harm_cnt;
	logic [5:0] off_cnt;
	logic [5:0] cross_cnt;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl_sh <= CTRL_RST;
			h4_sh <= FOURTH_HARM_STEADY_LEVEL_RST;
			mask_sh <= 32'h0000_0000;
		end
		else if (reg_wr && clk_en)
		begin
			if (reg_addr == ADDR_CTRL)
				ctrl_sh <= reg_wdata[4:0];
			if (reg_addr == ADDR_HARM_STA)
				h4_sh <= reg_wdata[15:8];
			if (reg_addr == ADDR_MASK)
			begin
				mask_sh <= reg_wdata;
			end
		end
	end

	// Settling counters, restarted by any write to keep them conservative
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || reg_wr)
		begin
			harm_cnt <= 6'h00;
			off_cnt <= 6'h00;
			cross_cnt <= 6'h00;
		end
		else
		begin
			harm_cnt <= !(ctrl_sh[1] && h4_pct[1] > h4_sh) ? 6'h00 : harm_cnt + 6'(harm_cnt != 6'h3F);
			off_cnt <= (ctrl_sh[3:0] != 4'h0) ? 6'h00 : off_cnt + 6'(off_cnt != 6'h3F);
			cross_cnt <= !ctrl_sh[4] ? 6'h00 : cross_cnt + 6'(cross_cnt != 6'h3F);
		end
	end

	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_rd_ctrl;
		clk_en && reg_rd && reg_addr == ADDR_CTRL;
	endsequence
	sequence s_rd_void;
		clk_en && reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr > ADDR_BASE);
	endsequence

	a_rd_idle_zero: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read");
	a_ctrl_readback: assert property (s_rd_ctrl |=> reg_rdata == {27'h000_0000, ctrl_sh})
		else $error("control readback differs");
	a_rd_unmapped: assert property (s_rd_void |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> trip == 3'h0 && restraint_active == 3'h0 && !irq)
		else $error("outputs not cleared by reset");
	a_irq_masked: assert property (mask_sh[STATUS_W-1:0] == '0 |-> !irq)
		else $error("interrupt with empty mask");
	a_harm_restrain: assert property (harm_cnt > 6'h28 |-> restraint_active[1])
		else $error("harmonic above level without restraint");
	a_enables_off: assert property (off_cnt > 6'h28 |-> restraint_active == 3'h0)
		else $error("restraint with all triggers disabled");
	a_cross_all: assert property (cross_cnt > 6'h28 |-> restraint_active inside {3'h0, 3'h7})
		else $error("cross block restrains single phase");
endmodule

bind dtr_core dtr_core_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.clk_en(clk_en),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.h4_pct(h4_pct),
	.trip(trip),
	.restraint_active(restraint_active),
	.irq(irq)
);
`default_nettype wire

// ---- sim/dtr_ct_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dtr_ct_model
	import dtr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Scenario settings
	input wire logic [7:0] gap,
	input wire logic [2:0][15:0] amp,
	input wire logic swing,
	input wire logic through,
	// Sampled currents toward the core
	output logic sample_valid,
	output logic [2:0][15:0] w1_sample,
	output logic [2:0][15:0] w2_sample
);
	// ********************
	// Sample pacing
	// ********************
	logic [7:0] cnt;
	logic [2:0] half;
	logic neg;

	// Without through, fed from winding one only; with it, winding two carries it out
	// Swing flips the sign every eight samples, giving zero crossings
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cnt <= 8'h00;
			sample_valid <= 1'b0;
			w1_sample <= '0;
			w2_sample <= '0;
			half <= 3'h0;
			neg <= 1'b0;
		end
		else
		begin
			sample_valid <= cnt == 8'h00;
			cnt <= (cnt == 8'h00) ? gap : cnt - 8'h01;
			if (cnt == 8'h00)
			begin
				half <= swing ? half + 3'h1 : 3'h0;
				if (swing && half == 3'h7)
					neg <= !neg;
				for (int p = 0; p < 3; p++)
				begin
					w1_sample[p] <= neg ? -amp[p] : amp[p];
					w2_sample[p] <= !through ? 16'h0000 : (neg ? amp[p] : -amp[p]);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/dtr_core.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R01) Active temporary restraint adds a constant offset to the restraining threshold.
// (R02) Each harmonic trigger restrains only when enabled and its ratio exceeds threshold.
// (R03) Saturation trigger restrains only when enabled and an external fault is seen.
// (R04) Cross-block setting chooses per-phase restraint or restraint of all three phases.
// (R05) Offset is a configured multiple of base current, scaled before adding.
// (R06) Second and fifth harmonics have separate transient and steady thresholds.
// (R07) Transient thresholds apply for a set time starting at energization.
// (R08) After the window, steady thresholds keep harmonic restraint while exceeded.
// (R09) At each zero crossing, rising stabilizing with flat differential starts or continues restraint.
// (R10) Two consecutive zero crossings with both currents rising remove saturation restraint.
// (R11) Saturation restraint never starts while an internal fault is present.
// (R12) Evolving fault under restraint delays trip at most about two cycles.
// (R13) Maximum stabilization timer ends saturation restraint regardless of detection.
// (R14) After saturation restraint ends, new saturation triggers are blocked for one second.
// (R15) Base current per winding is power over root three times voltage.
// (R16) Results are scaled to the winding one base current.
// (R17) Winding ratio mismatch is compensated numerically inside the block.
// (R18) Trip when differential reaches static curve plus any active offset.
// (R19) Zero crossing and saturation classification run separately for each phase.
module dtr_core
	import dtr_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)(
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Measurement chain, raw winding samples and harmonic ratios per phase
	input wire logic sample_valid,
	input wire logic [2:0][15:0] w1_sample,
	input wire logic [2:0][15:0] w2_sample,
	input wire logic [2:0][7:0] h2_pct,
	input wire logic [2:0][7:0] h4_pct,
	input wire logic [2:0][7:0] h5_pct,
	input wire logic [2:0][15:0] static_level,
	// Energization pin
	input wire logic energize_pin,
	// Results
	output logic [2:0] trip,
	output logic [2:0] restraint_active,
	output logic irq
);
	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic [4:0] ctrl;
	logic [7:0] second_harm_transient_level, fifth_harm_transient_level, second_harm_steady_level, fourth_harm_steady_level, fifth_harm_steady_level;
	logic [7:0] offset_mult;
	logic [15:0] t_trans, max_stab, sat_level, match;
	logic [23:0] power, volt_w1, volt_w2;
	logic [STATUS_W-1:0] status, mask, status_set;
	logic [31:0] next_rdata;
	logic [15:0] ib_w1, ib_w2;
	logic trans_active;
	logic [2:0] sat_act;
	logic base_dirty;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl <= CTRL_RST;
			second_harm_transient_level <= SECOND_HARM_TRANSIENT_LEVEL_RST;
			fifth_harm_transient_level <= FIFTH_HARM_TRANSIENT_LEVEL_RST;
			second_harm_steady_level <= SECOND_HARM_STEADY_LEVEL_RST;
			fourth_harm_steady_level <= FOURTH_HARM_STEADY_LEVEL_RST;
			fifth_harm_steady_level <= FIFTH_HARM_STEADY_LEVEL_RST;
			offset_mult <= OFFSET_MULT_RST;
			t_trans <= T_TRANS_RST;
			max_stab <= MAX_STAB_RST;
			sat_level <= SAT_LEVEL_RST;
			power <= POWER_RST;
			volt_w1 <= VOLT_RST;
			volt_w2 <= VOLT_RST;
			match <= MATCH_RST;
			mask <= '0;
		end
		else if (clk_en && reg_wr)
		begin
			unique case (reg_addr)
				ADDR_CTRL: ctrl <= reg_wdata[4:0];
				ADDR_HARM_TRA:
				begin
					second_harm_transient_level <= reg_wdata[7:0];
					fifth_harm_transient_level <= reg_wdata[15:8];
				end
				ADDR_HARM_STA:
				begin
					second_harm_steady_level <= reg_wdata[7:0];
					fourth_harm_steady_level <= reg_wdata[15:8];
					fifth_harm_steady_level <= reg_wdata[23:16];
				end
				ADDR_OFFSET_MULT: offset_mult <= reg_wdata[7:0];
				ADDR_T_TRANS: t_trans <= reg_wdata[15:0];
				ADDR_MAX_STAB: max_stab <= reg_wdata[15:0];
				ADDR_SAT_LEVEL: sat_level <= reg_wdata[15:0];
				ADDR_POWER: power <= reg_wdata[23:0];
				ADDR_VOLT_W1: volt_w1 <= reg_wdata[23:0];
				ADDR_VOLT_W2: volt_w2 <= reg_wdata[23:0];
				ADDR_MATCH: match <= reg_wdata[15:0];
				ADDR_MASK: mask <= reg_wdata[STATUS_W-1:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Read path, status and interrupt
	// ************************************************************
	always_comb
	begin
		next_rdata = '0;
		unique case (reg_addr)
			ADDR_CTRL: next_rdata[4:0] = ctrl;
			ADDR_HARM_TRA: next_rdata[15:0] = {fifth_harm_transient_level, second_harm_transient_level};
			ADDR_HARM_STA: next_rdata[23:0] = {fifth_harm_steady_level, fourth_harm_steady_level, second_harm_steady_level};
			ADDR_OFFSET_MULT: next_rdata[7:0] = offset_mult;
			ADDR_T_TRANS: next_rdata[15:0] = t_trans;
			ADDR_MAX_STAB: next_rdata[15:0] = max_stab;
			ADDR_SAT_LEVEL: next_rdata[15:0] = sat_level;
			ADDR_POWER: next_rdata[23:0] = power;
			ADDR_VOLT_W1: next_rdata[23:0] = volt_w1;
			ADDR_VOLT_W2: next_rdata[23:0] = volt_w2;
			ADDR_MATCH: next_rdata[15:0] = match;
			ADDR_STATUS: next_rdata[STATUS_W-1:0] = status;
			ADDR_MASK: next_rdata[STATUS_W-1:0] = mask;
			ADDR_STATE: next_rdata[9:0] = {sat_act, trans_active, restraint_active, trip};
			ADDR_BASE: next_rdata = {ib_w2, ib_w1};
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (clk_en)
			reg_rdata <= reg_rd ? next_rdata : '0;
	end

	// A new event in the clearing read survives the clear
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			status <= '0;
		else if (clk_en)
		begin
			if (reg_rd && reg_addr == ADDR_STATUS)
				status <= status_set;
			else
				status <= status | status_set;
		end
	end

	assign irq = |(status & mask);

	// ************************************************************
	// Millisecond tick
	// ************************************************************
	logic [13:0] tick_cnt;
	logic tick;

	assign tick = (tick_cnt == 14'(TICK_CYCLES - 1));

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			tick_cnt <= '0;
		else if (clk_en)
			tick_cnt <= tick ? '0 : tick_cnt + 14'h0001;
	end

	// ************************************************************
	// Energization pin and transient window
	// ************************************************************
	logic en_s1, en_s2, en_s3, en_level;
	logic [15:0] trans_cnt;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			en_s3 <= 1'b0;
			en_level <= 1'b0;
		end
		else if (clk_en)
		begin
			en_s1 <= energize_pin;
			en_s2 <= en_s1;
			en_s3 <= en_s2;
			if (en_s2 == en_s3)
				en_level <= en_s3;
		end
	end

	// Window starts at energization and counts down in ms
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			trans_cnt <= '0;
		else if (clk_en)
		begin
			if (en_s2 == en_s3 && en_s3 && !en_level)
				trans_cnt <= t_trans; // R07
			else if (tick && trans_cnt != '0)
				trans_cnt <= trans_cnt - 16'h0001;
		end
	end

	assign trans_active = (trans_cnt != '0); // R07

	assign status_set[ST_TRANS_END_BIT] = tick && trans_cnt == 16'h0001;

	// ************************************************************
	// Base current divider
	// ************************************************************
	// Serial divider: Ib = power * (1000/sqrt3) / voltage, one winding at a time
	logic div_run, div_sel;
	logic [5:0] div_step;
	logic [39:0] div_num;
	logic [24:0] div_rem;
	logic [24:0] div_try;
	logic [23:0] div_den;
	logic [15:0] div_q;

	assign div_den = div_sel ? volt_w2 : volt_w1;
	assign div_try = {div_rem[23:0], div_num[39]} - {1'b0, div_den};
	assign div_q = (div_num[39:16] != '0) ? 16'hFFFF : div_num[15:0];

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			base_dirty <= 1'b1;
		else if (clk_en)
		begin
			if (reg_wr && (reg_addr == ADDR_POWER || reg_addr == ADDR_VOLT_W1
				|| reg_addr == ADDR_VOLT_W2))
				base_dirty <= 1'b1;
			else if (!div_run)
				base_dirty <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			div_run <= 1'b0;
			div_sel <= 1'b0;
			div_step <= '0;
			div_num <= '0;
			div_rem <= '0;
			ib_w1 <= '0;
			ib_w2 <= '0;
		end
		else if (clk_en)
		begin
			if (!div_run)
			begin
				if (base_dirty || div_sel)
				begin
					div_run <= 1'b1;
					div_step <= '0;
					div_rem <= '0;
					div_num <= 40'(power * INV_SQRT3_K); // R15
				end
			end
			else if (div_step == DIV_STEPS)
			begin
				div_run <= 1'b0;
				div_sel <= !div_sel;
				if (div_sel)
					ib_w2 <= div_q; // R15
				else
					ib_w1 <= div_q; // R15
			end
			else
			begin
				div_step <= div_step + 6'h01;
				if (!div_try[24])
				begin
					div_rem <= div_try;
					div_num <= {div_num[38:0], 1'b1};
				end
				else
				begin
					div_rem <= {div_rem[23:0], div_num[39]};
					div_num <= {div_num[38:0], 1'b0};
				end
			end
		end
	end

	// ************************************************************
	// Restraint offset
	// ************************************************************
	logic [23:0] offset_prod;
	logic [15:0] offset_cur;

	// Offset multiple is Q4.4 times winding one base current
	assign offset_prod = offset_mult * ib_w1; // R05 R16

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			offset_cur <= '0;
		else if (clk_en)
			offset_cur <= (offset_prod[23:20] != '0) ? 16'hFFFF : offset_prod[19:4]; // R05
	end

	// ************************************************************
	// Per-phase evaluation
	// ************************************************************
	logic [2:0] harm_req, phase_req, sat_start, sat_end;

	function automatic logic [16:0] mag17(input logic signed [16:0] v);
		mag17 = v[16] ? 17'(-v) : v;
	endfunction

	for (genvar p = 0; p < 3; p++)
	begin : g_phase
		logic signed [32:0] w2_prod;
		logic signed [16:0] w2m, w1s, sum;
		logic [16:0] id_raw, is_raw;
		logic [15:0] diff_mag, stab_mag;
		logic prev_sign;
		logic [2:0] zc_cnt;
		logic eval, ext_fault, int_fault, int_prev;
		logic [15:0] stab_cnt, lock_cnt;
		logic [7:0] thr2, thr5;

		// Ratio mismatch: winding two scaled by Q8.8 match factor
		assign w2_prod = $signed(w2_sample[p]) * $signed({1'b0, match}); // R17
		assign w2m = 17'(w2_prod >>> 8); // R17
		assign w1s = 17'($signed(w1_sample[p]));
		assign sum = w1s + w2m;
		assign id_raw = mag17(sum);
		assign is_raw = 17'((18'(mag17(w1s)) + 18'(mag17(w2m))) >> 1);

		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
			begin
				diff_mag <= '0;
				stab_mag <= '0;
				prev_sign <= 1'b0;
			end
			else if (clk_en && sample_valid)
			begin
				diff_mag <= id_raw[16] ? 16'hFFFF : id_raw[15:0];
				stab_mag <= is_raw[16] ? 16'hFFFF : is_raw[15:0];
				prev_sign <= w1s[16];
			end
		end

		// Harmonic triggers
		assign thr2 = trans_active ? second_harm_transient_level : second_harm_steady_level; // R06 R08
		assign thr5 = trans_active ? fifth_harm_transient_level : fifth_harm_steady_level; // R06 R08
		assign harm_req[p] = (ctrl[CTRL_H2_BIT] && h2_pct[p] > thr2)
			|| (ctrl[CTRL_H4_BIT] && h4_pct[p] > fourth_harm_steady_level)
			|| (ctrl[CTRL_H5_BIT] && h5_pct[p] > thr5); // R02

		// Evaluate a few samples after each zero crossing, where the CT is clean
		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
				zc_cnt <= '0;
			else if (clk_en && sample_valid)
			begin
				if (w1s[16] != prev_sign)
					zc_cnt <= ZC_WIN; // R19
				else if (zc_cnt != '0)
					zc_cnt <= zc_cnt - 3'h1;
			end
		end

		assign eval = clk_en && sample_valid && zc_cnt == 3'h1;
		assign ext_fault = stab_mag > sat_level && diff_mag <= sat_level; // R09
		assign int_fault = stab_mag > sat_level && diff_mag > sat_level; // R10

		assign sat_start[p] = eval && ext_fault && ctrl[CTRL_SAT_BIT] && !sat_act[p]
			&& !int_prev && lock_cnt == '0; // R03 R11 R14
		assign sat_end[p] = clk_en && sat_act[p] && ((eval && int_fault && int_prev)
			|| (tick && stab_cnt == 16'h0001) || !ctrl[CTRL_SAT_BIT]); // R10 R12 R13

		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
			begin
				sat_act[p] <= 1'b0;
				int_prev <= 1'b0;
				stab_cnt <= '0;
				lock_cnt <= '0;
			end
			else if (clk_en)
			begin
				if (eval)
					int_prev <= int_fault; // R10
				if (sat_end[p])
				begin
					sat_act[p] <= 1'b0;
					stab_cnt <= '0;
					lock_cnt <= LOCKOUT_MS; // R14
				end
				else if (sat_start[p])
				begin
					sat_act[p] <= 1'b1; // R09
					stab_cnt <= max_stab; // R13
				end
				else
				begin
					if (tick && stab_cnt != '0)
						stab_cnt <= stab_cnt - 16'h0001; // R13
					if (tick && lock_cnt != '0)
						lock_cnt <= lock_cnt - 16'h0001; // R14
				end
			end
		end

		assign phase_req[p] = harm_req[p] || sat_act[p];

		// Trip compare against the raised curve
		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
			begin
				trip[p] <= 1'b0;
				restraint_active[p] <= 1'b0;
			end
			else if (clk_en)
			begin
				restraint_active[p] <= ctrl[CTRL_CROSS_BIT] ? |phase_req : phase_req[p]; // R04
				trip[p] <= 17'(diff_mag) >= 17'(static_level[p])
					+ (restraint_active[p] ? 17'(offset_cur) : 17'h0_0000); // R01 R18
			end
		end

		assign status_set[ST_TRIP_LSB + p] = clk_en && !trip[p] && 17'(diff_mag)
			>= 17'(static_level[p]) + (restraint_active[p] ? 17'(offset_cur) : 17'h0_0000);
	end

	assign status_set[ST_SAT_START_BIT] = |sat_start;
	assign status_set[ST_SAT_END_BIT] = |sat_end;
endmodule
`default_nettype wire

// ---- src/dtr_pkg.sv ----
package dtr_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_HARM_TRA = 8'h04;
	localparam logic [7:0] ADDR_HARM_STA = 8'h08;
	localparam logic [7:0] ADDR_OFFSET_MULT = 8'h0C;
	localparam logic [7:0] ADDR_T_TRANS = 8'h10;
	localparam logic [7:0] ADDR_MAX_STAB = 8'h14;
	localparam logic [7:0] ADDR_SAT_LEVEL = 8'h18;
	localparam logic [7:0] ADDR_POWER = 8'h1C;
	localparam logic [7:0] ADDR_VOLT_W1 = 8'h20;
	localparam logic [7:0] ADDR_VOLT_W2 = 8'h24;
	localparam logic [7:0] ADDR_MATCH = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2C;
	localparam logic [7:0] ADDR_MASK = 8'h30;
	localparam logic [7:0] ADDR_STATE = 8'h34;
	localparam logic [7:0] ADDR_BASE = 8'h38;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_H2_BIT = 0;
	localparam int CTRL_H4_BIT = 1;
	localparam int CTRL_H5_BIT = 2;
	localparam int CTRL_SAT_BIT = 3;
	localparam int CTRL_CROSS_BIT = 4;
	localparam int ST_TRIP_LSB = 0;
	localparam int ST_SAT_START_BIT = 3;
	localparam int ST_SAT_END_BIT = 4;
	localparam int ST_TRANS_END_BIT = 5;
	localparam int STATUS_W = 6;
	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [4:0] CTRL_RST = 5'h0F;
	localparam logic [7:0] SECOND_HARM_TRANSIENT_LEVEL_RST = 8'h0F;
	localparam logic [7:0] FIFTH_HARM_TRANSIENT_LEVEL_RST = 8'h1E;
	localparam logic [7:0] SECOND_HARM_STEADY_LEVEL_RST = 8'h14;
	localparam logic [7:0] FOURTH_HARM_STEADY_LEVEL_RST = 8'h14;
	localparam logic [7:0] FIFTH_HARM_STEADY_LEVEL_RST = 8'h1E;
	localparam logic [7:0] OFFSET_MULT_RST = 8'h10;
	localparam logic [15:0] T_TRANS_RST = 16'h03E8;
	localparam logic [15:0] MAX_STAB_RST = 16'h00C8;
	localparam logic [15:0] SAT_LEVEL_RST = 16'h0040;
	localparam logic [23:0] POWER_RST = 24'h00_2710;
	localparam logic [23:0] VOLT_RST = 24'h00_2710;
	localparam logic [15:0] MATCH_RST = 16'h0100;
	// ************************************************************
	// Timing and arithmetic
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES_DFLT = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] LOCKOUT_MS = 16'h03E8;
	localparam logic [2:0] ZC_WIN = 3'h4;
	localparam logic [9:0] INV_SQRT3_K = 10'h241;
	localparam logic [5:0] DIV_STEPS = 6'h28;
endpackage
